/* include/stc_pkg.sv */
// Package with constants and types of the sensor trim serial control block.
//
// Function
// - Frame starts only on select falling while trim clock is high.
// - Five status bits follow, each sampled on trim clock rising edge.
// - Select rises in fifth clock high, then clock falls to complete.
// - Completed code with only bit 4 set enters channel 1 trim.
// - Completed code with only bit 3 set enters channel 2 trim.
// - Completed all-zero code leaves trim mode for either channel.
// - Trim mode holds until a complete, terminated leave frame arrives.
// - Any reset, internal or external, returns device to normal operation.
// - Active trim with changing input drives a square wave on test output.
// - Supply monitor holds reset until supply safe, then initializes.
// - External reset overrides supply-monitor reset at any time.
// - External reset is active high; unconnected input means not in reset.
// - Both channels within 15 mV force the output into diagnostic region.
// - All timing derives from the on-chip oscillator clock.
// - A new output value is produced every update interval.
// - Output settles within the bounded system delay.
// - Active trim runs offset cancellation for the selected channel only.
package stc_pkg;

  // ****************************************************************
  // Frame and code constants
  // ****************************************************************
  localparam int unsigned CODE_BITS = 5;
  localparam logic [4:0]  CODE_TRIM_CH1 = 5'h08;
  localparam logic [4:0]  CODE_TRIM_CH2 = 5'h04;
  localparam logic [4:0]  CODE_LEAVE    = 5'h00;

  // ****************************************************************
  // Timing constants
  // ****************************************************************
  localparam int unsigned CLK_HZ          = 25_000_000;
  localparam int unsigned UPDATE_NS       = 260_000;
  localparam int unsigned UPDATE_CYCLES   = UPDATE_NS / (1_000_000_000 / CLK_HZ);
  localparam int unsigned TRIM_TEST_OUTPUT_HALF_NS    = 16_000;
  localparam int unsigned TRIM_TEST_OUTPUT_HALF_CYCLES =
    TRIM_TEST_OUTPUT_HALF_NS / (1_000_000_000 / CLK_HZ);
  localparam int unsigned INIT_NS         = 1_200_000;
  localparam int unsigned INIT_CYCLES     = INIT_NS / (1_000_000_000 / CLK_HZ);

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    STC_MODE_NORMAL = 2'b00,
    STC_MODE_TRIM1  = 2'b01,
    STC_MODE_TRIM2  = 2'b11
  } stc_mode_e;

  typedef enum logic [1:0] {
    STC_FR_IDLE = 2'b00,
    STC_FR_BITS = 2'b01,
    STC_FR_STOP = 2'b11,
    STC_FR_DONE = 2'b10
  } stc_frame_e;

  typedef struct packed {
    logic       valid;
    logic [4:0] code;
  } stc_code_s;

  typedef struct packed {
    logic       ch1_small;
    logic       ch2_small;
    logic       input_change;
  } stc_sense_s;

endpackage

/* design/stc_frame_rx.sv */
// Trim frame receiver: synchronizes the link pins and decodes frames.
`timescale 1ns/1ps
module stc_frame_rx (
  // Clock and reset
  input  wire logic              clk_in,
  input  wire logic              rst_n_in,
  // Link pins
  input  wire logic              trim_clock_in,
  input  wire logic              trim_select_line_in,
  // Decoded frame
  output stc_pkg::stc_code_s     code_out
);

  // ****************************************************************
  // Synchronizers
  // ****************************************************************
  logic [1:0] clk_sync;
  logic [1:0] sel_sync;
  logic       clk_d;
  logic       sel_d;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      clk_sync <= 2'h3;
      sel_sync <= 2'h3;
      clk_d    <= 1'b1;
      sel_d    <= 1'b1;
    end else begin
      clk_sync <= {clk_sync[0], trim_clock_in};
      sel_sync <= {sel_sync[0], trim_select_line_in};
      clk_d    <= clk_sync[1];
      sel_d    <= sel_sync[1];
    end
  end

  logic clk_rise;
  logic clk_fall;
  logic sel_fall;
  logic sel_rise;
  assign clk_rise = clk_sync[1] & ~clk_d;
  assign clk_fall = ~clk_sync[1] & clk_d;
  assign sel_fall = ~sel_sync[1] & sel_d;
  assign sel_rise = sel_sync[1] & ~sel_d;

  // ****************************************************************
  // Frame state machine
  // ****************************************************************
  stc_pkg::stc_frame_e state;
  stc_pkg::stc_frame_e next_state;
  logic [2:0]          count;
  logic [2:0]          next_count;
  logic [4:0]          shift;
  logic [4:0]          next_shift;
  stc_pkg::stc_code_s  next_code;

  always_comb begin
    next_state = state;
    next_count = count;
    next_shift = shift;
    next_code  = '{valid: 1'b0, code: shift};
    unique case (state)
      stc_pkg::STC_FR_IDLE: begin
        if (sel_fall && clk_d) begin
          next_state = stc_pkg::STC_FR_BITS;
          next_count = 3'h0;
        end
      end
      stc_pkg::STC_FR_BITS: begin
        if (clk_rise) begin
          // Bit 1 comes first and ends in code bit 0.
          next_shift = {sel_sync[1], shift[4:1]};
          next_count = count + 3'h1;
        end
        if (clk_rise && count == 3'(stc_pkg::CODE_BITS - 1)) begin
          next_state = stc_pkg::STC_FR_STOP;
        end
      end
      stc_pkg::STC_FR_STOP: begin
        // Select must rise during the fifth clock high phase.
        if (sel_rise && clk_d) begin
          next_state = stc_pkg::STC_FR_DONE;
        end else if (clk_fall || sel_fall) begin
          next_state = stc_pkg::STC_FR_IDLE;
        end
      end
      stc_pkg::STC_FR_DONE: begin
        if (clk_fall) begin
          next_code.valid = 1'b1;
          next_state      = stc_pkg::STC_FR_IDLE;
        end else if (sel_fall) begin
          next_state = stc_pkg::STC_FR_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state    <= stc_pkg::STC_FR_IDLE;
      count    <= 3'h0;
      shift    <= 5'h00;
      code_out <= '0;
    end else begin
      state    <= next_state;
      count    <= next_count;
      shift    <= next_shift;
      code_out <= next_code;
    end
  end

endmodule

/* design/stc_trim_control.sv */
// Top of the trim serial control: reset, trim mode, test output, update.
`timescale 1ns/1ps
module stc_trim_control #(
  parameter int unsigned UPDATE_CYCLES = stc_pkg::UPDATE_CYCLES,
  parameter int unsigned INIT_CYCLES   = stc_pkg::INIT_CYCLES,
  parameter int unsigned HALF_CYCLES   = stc_pkg::TRIM_TEST_OUTPUT_HALF_CYCLES
) (
  // Clock and resets
  input  wire logic            clk_in,
  input  wire logic            supply_ok_in,
  input  wire logic            external_reset_in,
  // Trim link
  input  wire logic            trim_clock_in,
  input  wire logic            trim_select_line_in,
  // Sensor status from the analog front end
  input  wire logic            ch1_small_in,
  input  wire logic            ch2_small_in,
  input  wire logic            input_change_in,
  // Outputs
  output logic                 trim_test_output,
  output logic                 trim_ch1_out,
  output logic                 trim_ch2_out,
  output logic                 init_busy_out,
  output logic                 update_strobe_out,
  output logic                 diag_force_out,
  output logic                 core_reset_n_out
);

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  if (UPDATE_CYCLES < 2 || INIT_CYCLES < 1 || HALF_CYCLES < 1) begin : g_bad
    $error("stc_trim_control: counts too small");
  end

  // ****************************************************************
  // Reset combination
  // ****************************************************************
  // The pin is active high and has a pull-down, so an open pin keeps
  // the device running; either the pin or the supply monitor holds reset.
  logic raw_rst_n;
  assign raw_rst_n = supply_ok_in & ~external_reset_in;

  // Asserts at once, releases through two flops to avoid a ragged
  // release across the design.
  logic [1:0] rst_sync;
  always_ff @(posedge clk_in or negedge raw_rst_n) begin
    if (!raw_rst_n) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  logic rst_n;
  assign rst_n = rst_sync[1];

  // ****************************************************************
  // Frame receiver
  // ****************************************************************
  stc_pkg::stc_code_s rx_code;

  stc_frame_rx u_rx (
    .clk_in              (clk_in),
    .rst_n_in            (rst_n),
    .trim_clock_in       (trim_clock_in),
    .trim_select_line_in (trim_select_line_in),
    .code_out            (rx_code)
  );

  // ****************************************************************
  // Sensor status synchronizers
  // ****************************************************************
  logic [2:0] sense_s1;
  logic [2:0] sense_s2;
  stc_pkg::stc_sense_s sense;
  logic       change_d;

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      sense_s1 <= 3'h0;
      sense_s2 <= 3'h0;
      change_d <= 1'b0;
    end else begin
      sense_s1 <= {ch1_small_in, ch2_small_in, input_change_in};
      sense_s2 <= sense_s1;
      change_d <= sense_s2[0];
    end
  end
  assign sense = sense_s2;

  // ****************************************************************
  // Mode and timing state
  // ****************************************************************
  stc_pkg::stc_mode_e mode;
  stc_pkg::stc_mode_e next_mode;
  logic [31:0]        init_cnt;
  logic [31:0]        next_init_cnt;
  logic [31:0]        upd_cnt;
  logic [31:0]        next_upd_cnt;
  logic [31:0]        half_cnt;
  logic [31:0]        next_half_cnt;
  logic [31:0]        idle_cnt;
  logic [31:0]        next_idle_cnt;
  logic               next_trim_test_output;
  logic               next_upd;
  logic               next_diag;
  logic               dynamic;

  // The input counts as changing while a change was seen within the
  // last update interval; a frozen input stops the square wave.
  assign dynamic = idle_cnt != 32'h0;

  always_comb begin
    next_mode     = mode;
    next_init_cnt = init_cnt;
    next_upd_cnt  = upd_cnt;
    next_half_cnt = half_cnt;
    next_idle_cnt = idle_cnt;
    next_trim_test_output     = trim_test_output;
    next_upd      = 1'b0;
    next_diag     = diag_force_out;

    if (init_cnt != 32'h0) begin
      next_init_cnt = init_cnt - 32'h1;
    end

    // Only the three defined codes change the mode.
    if (rx_code.valid) begin
      unique case (rx_code.code)
        stc_pkg::CODE_TRIM_CH1: next_mode = stc_pkg::STC_MODE_TRIM1;
        stc_pkg::CODE_TRIM_CH2: next_mode = stc_pkg::STC_MODE_TRIM2;
        stc_pkg::CODE_LEAVE:    next_mode = stc_pkg::STC_MODE_NORMAL;
        default:                next_mode = mode;
      endcase
    end

    // Update timing runs from the one oscillator clock.
    if (upd_cnt == 32'(UPDATE_CYCLES - 1)) begin
      next_upd_cnt = 32'h0;
      next_upd     = init_cnt == 32'h0;
      // Lost-input check is taken once per output value.
      next_diag    = sense.ch1_small & sense.ch2_small;
    end else begin
      next_upd_cnt = upd_cnt + 32'h1;
    end

    if (sense.input_change != change_d) begin
      next_idle_cnt = 32'(UPDATE_CYCLES);
    end else if (idle_cnt != 32'h0) begin
      next_idle_cnt = idle_cnt - 32'h1;
    end

    if (mode != stc_pkg::STC_MODE_NORMAL && dynamic) begin
      if (half_cnt == 32'(HALF_CYCLES - 1)) begin
        next_half_cnt = 32'h0;
        next_trim_test_output     = ~trim_test_output;
      end else begin
        next_half_cnt = half_cnt + 32'h1;
      end
    end else begin
      next_half_cnt = 32'h0;
      next_trim_test_output     = 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      mode              <= stc_pkg::STC_MODE_NORMAL;
      init_cnt          <= 32'(INIT_CYCLES);
      upd_cnt           <= 32'h0;
      half_cnt          <= 32'h0;
      idle_cnt          <= 32'h0;
      trim_test_output  <= 1'b0;
      update_strobe_out <= 1'b0;
      diag_force_out    <= 1'b0;
    end else begin
      mode              <= next_mode;
      init_cnt          <= next_init_cnt;
      upd_cnt           <= next_upd_cnt;
      half_cnt          <= next_half_cnt;
      idle_cnt          <= next_idle_cnt;
      trim_test_output  <= next_trim_test_output;
      update_strobe_out <= next_upd;
      diag_force_out    <= next_diag;
    end
  end

  // ****************************************************************
  // Registered status outputs
  // ****************************************************************
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      trim_ch1_out     <= 1'b0;
      trim_ch2_out     <= 1'b0;
      init_busy_out    <= 1'b1;
      core_reset_n_out <= 1'b0;
    end else begin
      // Offset cancellation runs for the selected channel only.
      trim_ch1_out     <= next_mode == stc_pkg::STC_MODE_TRIM1;
      trim_ch2_out     <= next_mode == stc_pkg::STC_MODE_TRIM2;
      init_busy_out    <= next_init_cnt != 32'h0;
      core_reset_n_out <= 1'b1;
    end
  end

endmodule

/* test/stc_trim_control_monitor.sv */
// Port checker of the trim serial control.
`timescale 1ns/1ps
module stc_trim_control_monitor #(
  parameter int unsigned UPDATE_CYCLES = 20
) (
  // Design inputs
  input wire logic clk_in,
  input wire logic supply_ok_in,
  input wire logic external_reset_in,
  input wire logic trim_select_line_in,
  // Design outputs
  input wire logic trim_ch1_out,
  input wire logic trim_ch2_out,
  input wire logic init_busy_out,
  input wire logic update_strobe_out,
  input wire logic diag_force_out,
  input wire logic core_reset_n_out
);
  // ********
  // Helper logic
  // ********
  // The internal reset combines both sources, so one signal disables all.
  wire logic sys_ok = supply_ok_in & ~external_reset_in;
  int   gap;
  logic seen;
  always_ff @(posedge clk_in or negedge sys_ok) begin
    if (!sys_ok) begin
      gap  <= 0;
      seen <= 1'b0;
    end else if (update_strobe_out) begin
      gap  <= 0;
      seen <= 1'b1;
    end else begin
      gap <= gap + 1;
    end
  end
  default clocking dc @(posedge clk_in); endclocking
  default disable iff (!sys_ok);
  // ********
  // Assertions
  // ********
  reset_clears_a: assert property (
    $rose(sys_ok) |-> !trim_ch1_out && !trim_ch2_out && init_busy_out)
    else $error("Trim mode survived a reset.");
  release_seq_a: assert property (
    $rose(sys_ok) |-> !core_reset_n_out ##1 !core_reset_n_out
      ##[1:2] core_reset_n_out)
    else $error("Core reset release out of step.");
  init_ends_a: assert property (
    $rose(core_reset_n_out) |-> init_busy_out ##[1:40] !init_busy_out)
    else $error("Initialization did not end.");
  strobe_gap_a: assert property (
    update_strobe_out && seen |-> gap == UPDATE_CYCLES - 1)
    else $error("Update interval wrong.");
  init_quiet_a: assert property (
    init_busy_out |-> !update_strobe_out)
    else $error("Update during initialization.");
  one_channel_a: assert property (
    !(trim_ch1_out && trim_ch2_out))
    else $error("Both channels in trim.");
  mode_frame_a: assert property (
    $changed({trim_ch1_out, trim_ch2_out}) |->
      trim_select_line_in && $past(trim_select_line_in, 4))
    else $error("Mode changed outside a frame end.");
  diag_tick_a: assert property (
    $changed(diag_force_out) |-> update_strobe_out ||
      $past(update_strobe_out))
    else $error("Fault flag moved off an update.");
  cover property ($rose(trim_ch1_out));
  cover property ($rose(trim_ch2_out));
  cover property ($rose(diag_force_out));
endmodule

bind stc_trim_control stc_trim_control_monitor #(
  .UPDATE_CYCLES(UPDATE_CYCLES)
) mon (
  .clk_in, .supply_ok_in, .external_reset_in, .trim_select_line_in,
  .trim_ch1_out, .trim_ch2_out, .init_busy_out, .update_strobe_out,
  .diag_force_out, .core_reset_n_out
);

/* test/stc_trim_programmer.sv */
// Model of the external trim programmer.
`timescale 1ns/1ps
module stc_trim_programmer (
  // Clock
  input  wire logic clk_in,
  // Link pins
  output logic      trim_clock_out,
  output logic      trim_select_out
);
  // Both lines idle high; the link clock stands still between frames.
  initial begin
    trim_clock_out  = 1'b1;
    trim_select_out = 1'b1;
  end
  // Four cycles a phase gives a 320 ns link period, 3.125 MHz.
  task automatic hold();
    repeat (4) @(posedge clk_in);
  endtask
  // An abort drops the clock before select rises in the last phase.
  task automatic send_frame(input logic [4:0] code, input logic abort);
    hold();
    trim_select_out <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      hold();
      trim_clock_out  <= 1'b0;
      trim_select_out <= code[i];
      hold();
      trim_clock_out <= 1'b1;
    end
    hold();
    if (!abort) begin
      trim_select_out <= 1'b1;
    end
    hold();
    trim_clock_out <= 1'b0;
    hold();
    trim_select_out <= 1'b1;
    trim_clock_out  <= 1'b1;
  endtask
endmodule

/* test/stc_trim_control_bench.sv */
// Self-checking bench of the trim serial control.
`timescale 1ns/1ps
module stc_trim_control_bench;
  // ********
  // Signals and design
  // ********
  localparam int unsigned UPD = 20;
  logic        clk_in = 1'b0;
  logic        supply_ok_in = 1'b0;
  logic        external_reset_in = 1'b0;
  logic        ch1_small_in = 1'b0;
  logic        ch2_small_in = 1'b0;
  logic        input_change_in = 1'b0;
  logic        wiggle = 1'b0;
  logic [31:0] seed = 32'h22;
  logic        trim_clock_in;
  logic        trim_select_line_in;
  logic        trim_test_output;
  logic        trim_ch1_out;
  logic        trim_ch2_out;
  logic        init_busy_out;
  logic        update_strobe_out;
  logic        diag_force_out;
  logic        core_reset_n_out;
  int          err_count = 0;
  int          total_checks = 0;
  logic [1:0]  exp_q[$];
  event        look_ev;
  always #20 clk_in = ~clk_in;
  stc_trim_programmer prog (.clk_in, .trim_clock_out(trim_clock_in),
    .trim_select_out(trim_select_line_in));
  stc_trim_control #(.UPDATE_CYCLES(UPD), .INIT_CYCLES(10),
    .HALF_CYCLES(4)) uut (.clk_in, .supply_ok_in, .external_reset_in,
    .trim_clock_in, .trim_select_line_in, .ch1_small_in, .ch2_small_in,
    .input_change_in, .trim_test_output, .trim_ch1_out, .trim_ch2_out,
    .init_busy_out, .update_strobe_out, .diag_force_out,
    .core_reset_n_out);
  // ********
  // Tasks
  // ********
  function automatic logic [31:0] next_rand();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    if (err_count == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Ready is waited for under a bound; a hang ends the run.
  task automatic wait_ready();
    int n;
    n = 0;
    while (core_reset_n_out !== 1'b1 || init_busy_out !== 1'b0) begin
      @(posedge clk_in);
      #1;
      n++;
      if (n > 300) begin
        err_count++;
        give_verdict();
      end
    end
    @(posedge clk_in);
  endtask
  task automatic expect_mode(input logic [1:0] exp);
    exp_q.push_back(exp);
    repeat (8) @(posedge clk_in);
    #1;
    -> look_ev;
  endtask
  task automatic frame(input logic [4:0] c, input logic ab,
                       input logic [1:0] exp);
    prog.send_frame(c, ab);
    expect_mode(exp);
  endtask
  task automatic pulse_reset(input logic use_ext);
    if (use_ext) begin
      external_reset_in <= 1'b1;
    end else begin
      supply_ok_in <= 1'b0;
    end
    repeat (2) @(posedge clk_in);
    #1;
    check("reset outs", 8'({core_reset_n_out, init_busy_out}), 8'h01);
    @(posedge clk_in);
    external_reset_in <= 1'b0;
    supply_ok_in      <= 1'b1;
    wait_ready();
    expect_mode(2'b00);
  endtask
  task automatic count_edges(input logic strobes, output int n);
    logic last;
    n = 0;
    last = trim_test_output;
    repeat (10 * UPD) begin
      @(posedge clk_in);
      #1;
      n += strobes ? int'(update_strobe_out) : int'(trim_test_output != last);
      last = trim_test_output;
    end
  endtask
  // ********
  // Checking and main sequence
  // ********
  always @(look_ev) begin
    check("mode", 8'({trim_ch1_out, trim_ch2_out}), 8'(exp_q.pop_front()));
  end
  always @(posedge clk_in) begin
    if (wiggle) begin
      input_change_in <= ^next_rand();
    end
  end
  initial begin
    int n;
    logic [4:0] junk;
    repeat (3) @(posedge clk_in);
    supply_ok_in <= 1'b1;
    wait_ready();
    count_edges(1'b1, n);
    check("update ticks", 8'(n), 8'h0a);
    frame(stc_pkg::CODE_TRIM_CH1, 1'b0, 2'b10);
    do begin
      junk = 5'(next_rand());
    end while (junk == 5'h00 || junk == 5'h04 || junk == 5'h08);
    frame(junk, 1'b0, 2'b10);
    frame(stc_pkg::CODE_LEAVE, 1'b1, 2'b10);
    wiggle <= 1'b1;
    count_edges(1'b0, n);
    check("wave", 8'(n >= 40), 8'h01);
    frame(stc_pkg::CODE_TRIM_CH2, 1'b0, 2'b01);
    frame(stc_pkg::CODE_LEAVE, 1'b0, 2'b00);
    count_edges(1'b0, n);
    check("quiet wave", 8'(n), 8'h00);
    frame(stc_pkg::CODE_TRIM_CH1, 1'b0, 2'b10);
    pulse_reset(1'b1);
    frame(stc_pkg::CODE_TRIM_CH2, 1'b0, 2'b01);
    pulse_reset(1'b0);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_in);
      ch1_small_in <= 1'b1;
      ch2_small_in <= (i == 0);
      repeat (3 * UPD) @(posedge clk_in);
      #1;
      check("diag", 8'(diag_force_out), 8'(i == 0));
    end
    give_verdict();
  end
endmodule
